// *** design/rie_interrupt_logic.sv ***
// rie_interrupt_logic: enable, pending and output-enable set for two terminals
// assumes the host port strobes are one-cycle pulses synchronous to clk
`timescale 1ns/1ps
module rie_interrupt_logic #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  // terminal event reports
  input wire rie_pkg::rie_evt_t first_remote_terminal,
  input wire rie_pkg::rie_evt_t second_remote_terminal,
  // configuration bits
  input wire logic host_request_suppress_on_error,
  input wire logic log_busy_flag_select,
  // other interrupt sources and summary register
  input wire logic other_irq_pending,
  input wire logic summary_clear,
  output logic remote_terminal_summary_pending,
  // log buffer writer
  output logic log_wr,
  output rie_pkg::rie_log_t log_entry,
  // host request and reset-request pins
  output logic host_irq_n,
  output logic [1:0] reset_request
);
  // registers
  logic [DATA_W-1:0] rt_pending_interrupts;
  logic [DATA_W-1:0] rt_interrupt_enables;
  logic [DATA_W-1:0] rt_interrupt_output_enables;
  // request from this block's own terminals
  logic rt_irq_flag;
  logic next_rt_irq;
  // second terminal's log entry waiting behind the first
  logic log_hold;
  logic [DATA_W-1:0] log_hold_word;
  // collector results
  logic [DATA_W-1:0] set_1, set_2, set_any;
  logic [DATA_W-1:0] lword_1, lword_2;
  logic lreq_1, lreq_2;
  logic raise_1, raise_2, raise_any;
  logic rreq_1, rreq_2;
  // decoded host accesses
  logic pend_rd;
  logic next_pend_nonzero;
  logic [DATA_W-1:0] next_pending;

  // address decode for the register map
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [6:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  // per-terminal message collection
  rie_msg_collect u_first (
    .clk(clk),
    .sys_rst(sys_rst),
    .evt(first_remote_terminal),
    .enables(rt_interrupt_enables),
    .out_enables(rt_interrupt_output_enables),
    .suppress_on_error(host_request_suppress_on_error),
    .log_busy_flag_select(log_busy_flag_select),
    .set_bits(set_1),
    .log_req(lreq_1),
    .log_word(lword_1),
    .raise(raise_1),
    .reset_request(rreq_1)
  );

  rie_msg_collect u_second (
    .clk(clk),
    .sys_rst(sys_rst),
    .evt(second_remote_terminal),
    .enables(rt_interrupt_enables),
    .out_enables(rt_interrupt_output_enables),
    .suppress_on_error(host_request_suppress_on_error),
    .log_busy_flag_select(log_busy_flag_select),
    .set_bits(set_2),
    .log_req(lreq_2),
    .log_word(lword_2),
    .raise(raise_2),
    .reset_request(rreq_2)
  );

  // combine both terminals and work out the next pending value
  always_comb begin
    set_any = set_1 | set_2;
    raise_any = raise_1 | raise_2;
    pend_rd = reg_rd && hit(reg_addr, rie_pkg::OFS_PENDING);
    // read clears, but bits set in the same cycle survive
    if (pend_rd) begin
      next_pending = set_any;
    end else begin
      next_pending = rt_pending_interrupts | set_any;
    end
    next_pend_nonzero = |(next_pending & rt_interrupt_output_enables);
    // latch a raise; drop once nothing output-enabled remains
    next_rt_irq = raise_any || (rt_irq_flag && next_pend_nonzero);
  end

  // pending register; reserved bit never sets
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rt_pending_interrupts <= rie_pkg::RST_WORD;
    end else begin
      rt_pending_interrupts <= next_pending & rie_pkg::PEND_MASK;
    end
  end

  // enable registers written by the host
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rt_interrupt_enables <= rie_pkg::RST_WORD;
      rt_interrupt_output_enables <= rie_pkg::RST_WORD;
    end else if (reg_wr) begin
      // pending is read-clear only; writes to it are dropped
      if (hit(reg_addr, rie_pkg::OFS_ENABLES)) begin
        rt_interrupt_enables <= reg_wdata;
      end
      if (hit(reg_addr, rie_pkg::OFS_OUT_EN)) begin
        rt_interrupt_output_enables <= reg_wdata;
      end
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= rie_pkg::RST_WORD;
    end else if (reg_rd) begin
      if (hit(reg_addr, rie_pkg::OFS_PENDING)) begin
        reg_rdata <= rt_pending_interrupts;
      end else if (hit(reg_addr, rie_pkg::OFS_ENABLES)) begin
        reg_rdata <= rt_interrupt_enables;
      end else if (hit(reg_addr, rie_pkg::OFS_OUT_EN)) begin
        reg_rdata <= rt_interrupt_output_enables;
      end else begin
        reg_rdata <= rie_pkg::RST_WORD;
      end
    end
  end

  // shared summary bit; a new set wins over the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      remote_terminal_summary_pending <= 1'b0;
    end else if (|set_any) begin
      remote_terminal_summary_pending <= 1'b1;
    end else if (summary_clear) begin
      remote_terminal_summary_pending <= 1'b0;
    end
  end

  // request flag and the shared active-low host line
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rt_irq_flag <= 1'b0;
      host_irq_n <= 1'b1;
    end else begin
      rt_irq_flag <= next_rt_irq;
      host_irq_n <= !(next_rt_irq || other_irq_pending);
    end
  end

  // log writer: first terminal first, second waits for a cycle with no first-terminal entry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      log_wr <= 1'b0;
      log_entry <= '0;
      log_hold <= 1'b0;
      log_hold_word <= rie_pkg::RST_WORD;
    end else begin
      log_wr <= lreq_1 || lreq_2 || log_hold;
      if (lreq_1) begin
        // both ends together: park the second entry
        log_entry <= '{terminal: 1'b0, word: lword_1};
        log_hold <= lreq_2 || log_hold;
        if (lreq_2) begin
          log_hold_word <= lword_2;
        end
      end else if (log_hold) begin
        // drain the parked entry, take a fresh one behind it
        log_entry <= '{terminal: 1'b1, word: log_hold_word};
        log_hold <= lreq_2;
        if (lreq_2) begin
          log_hold_word <= lword_2;
        end
      end else if (lreq_2) begin
        log_entry <= '{terminal: 1'b1, word: lword_2};
      end
    end
  end

  // reset-request pins, one pulse per disabled reset command
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_request <= 2'b00;
    end else begin
      reset_request <= {rreq_2, rreq_1};
    end
  end

  // checks on the logic above
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // with nothing enabled, pending stays clear
  a_disabled_ignored: assert property (
    (rt_interrupt_enables == '0 && rt_pending_interrupts == '0) |=>
      rt_pending_interrupts == '0)
    else $error("pending set while all events disabled");

  // set bits land and old bits stay
  a_pending_or_in: assert property (
    !pend_rd |=> rt_pending_interrupts ==
      (($past(rt_pending_interrupts) | $past(set_any)) & rie_pkg::PEND_MASK))
    else $error("pending bits lost or not set");

  // read returns old value and then clears
  a_read_clears: assert property (
    (pend_rd && set_any == '0) |=>
      (rt_pending_interrupts == '0 && reg_rdata == $past(rt_pending_interrupts)))
    else $error("pending read did not return and clear");

  // summary follows any enabled event
  a_summary_set: assert property (
    (|set_any) |=> remote_terminal_summary_pending)
    else $error("summary bit not set");

  // summary stays up until the host clears it
  a_summary_hold: assert property (
    (remote_terminal_summary_pending && !summary_clear) |=> remote_terminal_summary_pending)
    else $error("summary bit dropped without a clear");

  // reserved pending bit never reads one
  a_reserved_zero: assert property (
    !rt_pending_interrupts[rie_pkg::BIT_RESERVED])
    else $error("reserved pending bit set");

  // line only falls on a completion or another source
  a_irq_at_done: assert property (
    ($fell(host_irq_n) && !$past(other_irq_pending)) |-> $past(raise_any))
    else $error("host request before message completion");

  // an idle line stays idle while no message completes
  a_no_early_irq: assert property (
    (host_irq_n && !raise_any && !other_irq_pending) |=> host_irq_n)
    else $error("host request without a completion");

  // an output-enabled completion pulls the line low
  a_raise_asserts: assert property (
    raise_any |=> !host_irq_n)
    else $error("host request missing after completion");

  // both terminals finishing together give one shared request
  a_both_raise: assert property (
    (raise_1 && raise_2) |=> (!host_irq_n && rt_irq_flag))
    else $error("simultaneous completions lost the request");

  // other pending sources share the same line
  a_other_source: assert property (
    other_irq_pending |=> !host_irq_n)
    else $error("shared request not driven for other source");

  // low priority completion leaves line high
  a_low_priority: assert property (
    (first_remote_terminal.msg_done && rt_interrupt_output_enables == '0 &&
     !rt_irq_flag && !raise_2 && !other_irq_pending) |=> host_irq_n)
    else $error("low priority event raised the request");

  // error or busy blocks the request when suppressed
  a_suppress_err: assert property (
    (host_request_suppress_on_error && first_remote_terminal.msg_done &&
     (first_remote_terminal.msg_error || first_remote_terminal.msg_busy)) |-> !raise_1)
    else $error("request raised despite suppress option");

  // request released once cleared by a read
  a_irq_release: assert property (
    (pend_rd && set_any == '0 && !raise_any && !other_irq_pending) |=> host_irq_n)
    else $error("request held after pending cleared");

  // every completed second-terminal message with enabled events is logged soon
  a_log_written: assert property (
    lreq_2 |-> ##[1:3] (log_wr && log_entry.terminal))
    else $error("log entry missing");

  // first terminal entry goes out next cycle with its word
  a_log_first: assert property (
    lreq_1 |=> (log_wr && !log_entry.terminal && log_entry.word == $past(lword_1)))
    else $error("first terminal log entry wrong");

  // second terminal entry alone goes out next cycle with its word
  a_log_second: assert property (
    (lreq_2 && !lreq_1 && !log_hold) |=>
      (log_wr && log_entry.terminal && log_entry.word == $past(lword_2)))
    else $error("second terminal log entry wrong");

  // no log write without an entry to send
  a_log_quiet: assert property (
    (!lreq_1 && !lreq_2 && !log_hold) |=> !log_wr)
    else $error("log write without an entry");

  // disabled reset command pulses its pin and never pends
  a_reset_pin: assert property (
    rreq_1 |=> (reset_request[0] &&
      !$rose(rt_pending_interrupts[rie_pkg::BIT_RESET_CMD])))
    else $error("reset request pin not asserted");

  // same for the second terminal's pin
  a_reset_pin_two: assert property (
    rreq_2 |=> (reset_request[1] &&
      !$rose(rt_pending_interrupts[rie_pkg::BIT_RESET_CMD])))
    else $error("second reset request pin not asserted");

  // scenarios worth seeing
  c_high_irq: cover property (raise_1 ##1 !host_irq_n);
  c_both_done: cover property (lreq_1 && lreq_2);
  c_read_clear: cover property (pend_rd && rt_pending_interrupts != '0);
  c_suppressed: cover property (first_remote_terminal.msg_error && lreq_1 && !raise_1);
  c_reset_pin: cover property (rreq_1 || rreq_2);
endmodule

// *** pkg/rie_pkg.sv ***
// rie_pkg: shared constants and carriers for the terminal interrupt logic
// assumes a 16-bit word register map reached by word address
package rie_pkg;
  // register word addresses
  localparam logic [6:0] OFS_PENDING = 7'h09;
  localparam logic [6:0] OFS_ENABLES = 7'h12;
  localparam logic [6:0] OFS_OUT_EN = 7'h16;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  // bit positions
  localparam int BIT_RESERVED = 9;
  localparam int BIT_RESET_CMD = 15;
  localparam int BIT_SUMMARY = 1;
  // mask of bits that may ever be pending
  localparam logic [15:0] PEND_MASK = 16'hFDFF;
  // one terminal's per-cycle event report
  typedef struct packed {
    logic [15:0] events;
    logic msg_done;
    logic msg_error;
    logic msg_busy;
  } rie_evt_t;
  // one log buffer entry request
  typedef struct packed {
    logic terminal;
    logic [15:0] word;
  } rie_log_t;
endpackage

// *** design/rie_msg_collect.sv ***
// rie_msg_collect: gathers one terminal's enabled events over a message
// assumes event bits and message end flags are synchronous to clk
`timescale 1ns/1ps
module rie_msg_collect (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // event report and settings
  input wire rie_pkg::rie_evt_t evt,
  input wire logic [15:0] enables,
  input wire logic [15:0] out_enables,
  input wire logic suppress_on_error,
  input wire logic log_busy_flag_select,
  // results
  output logic [15:0] set_bits,
  output logic log_req,
  output logic [15:0] log_word,
  output logic raise,
  output logic reset_request
);
  // enabled bits seen so far in this message
  logic [15:0] acc;
  // message held an output-enabled event
  logic hi_acc;
  // bits of this cycle and of the whole message
  logic [15:0] msg_bits;
  logic hi_now;

  // only currently enabled events count; earlier ones are never replayed
  always_comb begin
    set_bits = evt.events & enables & rie_pkg::PEND_MASK;
    msg_bits = acc | set_bits;
    hi_now = hi_acc | (|(set_bits & out_enables));
  end

  // accumulate until the message ends
  always_ff @(posedge clk) begin
    if (sys_rst || evt.msg_done) begin
      acc <= rie_pkg::RST_WORD;
      hi_acc <= 1'b0;
    end else begin
      acc <= msg_bits;
      hi_acc <= hi_now;
    end
  end

  // end-of-message outputs
  always_comb begin
    log_req = evt.msg_done && (|msg_bits);
    log_word = msg_bits;
    // reserved pending bit carries busy status in the log copy
    log_word[rie_pkg::BIT_RESERVED] = log_busy_flag_select && evt.msg_busy;
    // request is raised only at completion, and not for error or busy when suppress_on_error is set
    raise = evt.msg_done && hi_now &&
            !(suppress_on_error && (evt.msg_error || evt.msg_busy));
    // a disabled reset command goes to the dedicated pin instead
    reset_request = evt.events[rie_pkg::BIT_RESET_CMD] &&
                    !enables[rie_pkg::BIT_RESET_CMD];
  end
endmodule

// *** testbench/rie_host_model.sv ***
// rie_host_model: host processor servicing the terminal interrupt registers
// assumes a strobe on the register port is taken at the next rising edge of clk
`timescale 1ns/1ps
module rie_host_model (
  // clock
  input wire logic clk,
  // register port toward the device
  output logic [6:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // request from the device
  input wire logic host_irq_n
);
  // port idle from time zero
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // one strobe cycle, released only after the taking edge has passed
  task automatic access(input logic w, input logic [6:0] a, input logic [15:0] d,
      output logic [15:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk);
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // released lines do not keep the last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // single word write
  task automatic write_reg(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] q;
    access(1'b1, a, d, q);
  endtask
  // single word read
  task automatic read_reg(input logic [6:0] a, output logic [15:0] q);
    access(1'b0, a, 16'h0000, q);
  endtask
  // service after a request, or poll when none came; nonzero names the events
  task automatic service(output logic [15:0] q);
    if (host_irq_n === 1'b0)
      read_reg(rie_pkg::OFS_PENDING, q);
    else
      read_reg(rie_pkg::OFS_PENDING, q);
  endtask
endmodule

// *** testbench/rie_interrupt_logic_test.sv ***
// rie_interrupt_logic_test: self-checking bench for the terminal interrupt logic
// assumes rie_host_model owns the register port on the same clock
`timescale 1ns/1ps
module rie_interrupt_logic_test;
  localparam logic [15:0] M = rie_pkg::PEND_MASK;
  // stimulus and observed signals
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  rie_pkg::rie_evt_t ev1 = '0;
  rie_pkg::rie_evt_t ev2 = '0;
  logic sup = 1'b0;
  logic sel = 1'b0;
  logic oth = 1'b0;
  logic sclr = 1'b0;
  logic [6:0] addr;
  logic wr, rd, summ, lwr, irq_n;
  logic [15:0] wdata, rdata, en, oe;
  rie_pkg::rie_log_t lent;
  logic [1:0] rreq;
  int errors = 0;
  int n_checks = 0;
  int rr[2] = '{0, 0};
  rie_pkg::rie_log_t logq[$];
  // 100 MHz clock
  always #5 clk = ~clk;
  rie_interrupt_logic i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .first_remote_terminal(ev1),
    .second_remote_terminal(ev2), .host_request_suppress_on_error(sup),
    .log_busy_flag_select(sel), .other_irq_pending(oth), .summary_clear(sclr),
    .remote_terminal_summary_pending(summ), .log_wr(lwr), .log_entry(lent),
    .host_irq_n(irq_n), .reset_request(rreq));
  rie_host_model i_host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .host_irq_n(irq_n));
  // collect log entries and reset-request pulses
  always @(posedge clk) begin
    if (lwr === 1'b1)
      logq.push_back(lent);
    if (rreq[0] === 1'b1)
      rr[0]++;
    if (rreq[1] === 1'b1)
      rr[1]++;
  end
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // word comparison
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // one cycle of terminal reports
  task automatic put(input logic [15:0] x1, x2, input logic [1:0] d, input logic er, bz);
    @(negedge clk);
    ev1 = '{x1, d[0], er, bz};
    ev2 = '{x2, d[1], er, bz};
  endtask
  // write both enable words and read them back
  task automatic set_regs(input logic [15:0] e, o);
    logic [15:0] q;
    i_host.write_reg(rie_pkg::OFS_ENABLES, e);
    i_host.write_reg(rie_pkg::OFS_OUT_EN, o);
    i_host.read_reg(rie_pkg::OFS_ENABLES, q);
    check_word(q, e, "enables");
    i_host.read_reg(rie_pkg::OFS_OUT_EN, q);
    check_word(q, o, "output enables");
    en = e;
    oe = o;
  endtask
  // one message: events over two cycles, completion, then host service
  task automatic run_msg(input logic [15:0] x1, x2, input logic [1:0] d, input logic er, bz);
    logic [15:0] x[2];
    logic [15:0] w[2];
    logic [15:0] q;
    logic fire;
    int n;
    int r0[2];
    x = '{x1, x2};
    w = '{x1 & en & M, x2 & en & M};
    fire = ((|(w[0] & oe) && d[0]) || (|(w[1] & oe) && d[1])) && !(sup && (er || bz));
    n = int'(d[0] && w[0] != 0) + int'(d[1] && w[1] != 0);
    r0 = rr;
    logq.delete();
    put(x1 & 16'h00FF, x2, 2'b00, 1'b0, 1'b0);
    put(x1 & 16'hFF00, '0, 2'b00, 1'b0, 1'b0);
    put('0, '0, d, er, bz);
    check_word(16'(irq_n), 16'h0001, "request before completion");
    put('0, '0, 2'b00, 1'b0, 1'b0);
    for (int i = 0; logq.size() < n; i++) begin
      if (i == 8) begin
        errors++;
        $display("[ERR] %0t log wait timed out", $time);
        report_and_stop();
      end
      @(negedge clk);
    end
    repeat (2) @(negedge clk);
    check_word(16'(logq.size()), 16'(n), "log count");
    for (int i = 0; i < 2; i++) begin
      if (d[i] && w[i] != 0 && logq.size() > 0) begin
        check_word(logq[0].word, w[i] | (16'(sel && bz) << 9), "log word");
        check_word(16'(logq[0].terminal), 16'(i), "log terminal");
        void'(logq.pop_front());
      end
      check_word(16'(rr[i] - r0[i]), 16'(x[i][15] && !en[15]), "reset pulses");
    end
    check_word(16'(irq_n), 16'(!fire), "request level");
    check_word(16'(summ), 16'(|(w[0] | w[1])), "summary");
    i_host.service(q);
    check_word(q, w[0] | w[1], "pending");
    repeat (2) @(negedge clk);
    check_word(16'(irq_n), 16'h0001, "request released");
    i_host.read_reg(rie_pkg::OFS_PENDING, q);
    check_word(q, 16'h0000, "pending cleared");
    sclr = 1'b1;
    @(negedge clk);
    sclr = 1'b0;
    @(negedge clk);
    check_word(16'(summ), 16'h0000, "summary cleared");
  endtask
  // main sequence
  initial begin
    logic [15:0] q;
    logic [15:0] v;
    logic t;
    logic [6:0] a[4];
    a = '{rie_pkg::OFS_PENDING, rie_pkg::OFS_ENABLES, rie_pkg::OFS_OUT_EN, 7'h00};
    void'($urandom(58818));
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    foreach (a[i]) begin
      i_host.read_reg(a[i], q);
      check_word(q, 16'h0000, "reset value");
    end
    i_host.write_reg(rie_pkg::OFS_PENDING, 16'hFFFF);
    i_host.read_reg(rie_pkg::OFS_PENDING, q);
    check_word(q, 16'h0000, "pending write ignored");
    $display("test reset done");
    set_regs(16'hFFFF, 16'hFFFF);
    run_msg(16'h0008, '0, 2'b01, 1'b0, 1'b0);
    run_msg(16'h0003, 16'h0300, 2'b11, 1'b0, 1'b0);
    sup = 1'b1;
    sel = 1'b1;
    run_msg(16'h0010, '0, 2'b01, 1'b1, 1'b0);
    run_msg('0, 16'h0020, 2'b10, 1'b0, 1'b1);
    sup = 1'b0;
    set_regs(16'hFFFF, 16'h0000);
    run_msg(16'h4001, '0, 2'b01, 1'b0, 1'b0);
    set_regs(16'h00F0, 16'hFFFF);
    run_msg(16'h800F, 16'h8000, 2'b11, 1'b0, 1'b0);
    set_regs(16'h0000, 16'hFFFF);
    put(16'h0010, '0, 2'b00, 1'b0, 1'b0);
    put('0, '0, 2'b00, 1'b0, 1'b0);
    set_regs(16'hFFFF, 16'hFFFF);
    run_msg('0, '0, 2'b01, 1'b0, 1'b0);
    $display("test corner cases done");
    oth = 1'b1;
    repeat (2) @(negedge clk);
    check_word(16'(irq_n), 16'h0000, "shared request");
    oth = 1'b0;
    repeat (2) @(negedge clk);
    check_word(16'(irq_n), 16'h0001, "shared request off");
    $display("test shared request done");
    for (int k = 0; k < 16; k++) begin
      sup = 1'($urandom);
      sel = 1'($urandom);
      set_regs(16'($urandom), 16'($urandom));
      t = 1'($urandom);
      v = 16'($urandom);
      run_msg(t ? '0 : v, t ? v : '0, t ? 2'b10 : 2'b01, 1'($urandom), 1'($urandom));
    end
    $display("test random messages done");
    report_and_stop();
  end
endmodule
